//--- common/pfoc_pkg.sv
// Constants of the packet format and averaging control block
// Overview of operation
// RULE1 - Fixed pattern replaces packets using pattern upper bits
// RULE2 - Host uses fixed pattern to check bus
// RULE3 - Two-bit size field sets packet size
// RULE4 - Code 00 gives 20 bits, 01 gives 24
// RULE5 - Codes 10 and 11 both give 32 bits
// RULE6 - Packet layout depends on averaging and pattern
// RULE7 - Enable bit: 0 plain, 1 averaging
// RULE8 - Host clears enable before changing count code
// RULE9 - Average two to power code-plus-one results per channel
// RULE10 - Averaging emits one result per completed group
`default_nettype none
package pfoc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_PACKET_FORMAT = 8'h26;
    localparam logic [7:0]  IDX_AVG_CONTROL   = 8'h27;
    localparam logic [7:0]  IDX_PATTERN_BASE  = 8'h30;
    localparam logic [7:0]  IDX_STATUS        = 8'h34;
    localparam int          IDX_LSB           = 2;
    localparam int          IDX_MSB           = 9;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0]  PACKET_FORMAT_RST = 8'h01;
    localparam logic [7:0]  AVG_CONTROL_RST   = 8'h00;
    localparam logic [31:0] PATTERN_RST       = 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int          SIZE_LSB          = 0;
    localparam int          SIZE_MSB          = 1;
    localparam int          FIXED_PAT_BIT     = 2;
    localparam int          AVG_EN_BIT        = 7;
    localparam int          AVG_CODE_LSB      = 0;
    localparam int          AVG_CODE_MSB      = 3;
    localparam int          STAT_AVG_BIT      = 0;
    localparam int          STAT_FIX_BIT      = 1;
    localparam int          STAT_CNT_LSB      = 16;

    ////////////////////////////////////////////////////////////////////////
    // Packet size codes and datapath widths
    localparam logic [1:0]  SIZE_20           = 2'h0;
    localparam logic [1:0]  SIZE_24           = 2'h1;
    localparam int          LANE_W            = 32;
    localparam int          SAMPLE_W          = 20;
    localparam int          FRAC_W            = 4;
    localparam int          AVG_W             = 24;
    localparam int          CODE_W            = 4;
    localparam int          CNT_W             = 17;
    localparam int          NUM_CH            = 4;

endpackage
`default_nettype wire

//--- hdl/pfoc_avg.sv
// One channel of the digital averaging engine
`default_nettype none
module pfoc_avg #(
    parameter int SAMPLE_W = pfoc_pkg::SAMPLE_W
) (
    // Clock, reset, enable
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    input  wire logic                        ce,
    // Mode
    input  wire logic                        avg_en,
    input  wire logic [pfoc_pkg::CODE_W-1:0] avg_code,
    // Conversion result in
    input  wire logic                        in_valid,
    input  wire logic [SAMPLE_W-1:0]         in_data,
    // Averaged result out
    output logic                             out_valid,
    output logic [pfoc_pkg::AVG_W-1:0]       out_data
);
    localparam int ACC_W = SAMPLE_W + 16;
    localparam int EXT_W = ACC_W + pfoc_pkg::FRAC_W;

    logic signed [ACC_W-1:0]          acc_ff, nxt_acc;
    logic [pfoc_pkg::CNT_W-1:0]       cnt_ff, nxt_cnt;
    logic                             vld_ff, nxt_vld;
    logic [pfoc_pkg::AVG_W-1:0]       dat_ff, nxt_dat;
    logic signed [ACC_W-1:0]          sum;
    logic [pfoc_pkg::CNT_W-1:0]       last_cnt;
    logic signed [EXT_W-1:0]          scaled;

    ////////////////////////////////////////////////////////////////////////
    // Group of 2^(code+1); five-bit shift so code 15 cannot wrap
    always_comb begin
        last_cnt = (pfoc_pkg::CNT_W'(1) << ({1'b0, avg_code} + 5'h01))
                 - pfoc_pkg::CNT_W'(1); // RULE9
        sum      = acc_ff + ACC_W'($signed(in_data));
        scaled   = $signed({sum, {pfoc_pkg::FRAC_W{1'b0}}})
                 >>> ({1'b0, avg_code} + 5'h01); // RULE9
        nxt_acc  = acc_ff;
        nxt_cnt  = cnt_ff;
        nxt_vld  = 1'b0;
        nxt_dat  = dat_ff;
        if (!avg_en) begin
            // Disabled engine restarts clean, so a new code is safe
            nxt_acc = '0; // RULE8
            nxt_cnt = '0;
        end else if (in_valid) begin
            if (cnt_ff == last_cnt) begin
                // Group done: one result, restart
                nxt_vld = 1'b1; // RULE10
                nxt_dat = scaled[pfoc_pkg::AVG_W-1:0];
                nxt_acc = '0;
                nxt_cnt = '0;
            end else begin
                nxt_acc = sum;
                nxt_cnt = cnt_ff + pfoc_pkg::CNT_W'(1);
            end
        end
    end

    // State registers, frozen while ce is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_ff <= '0;
            cnt_ff <= '0;
            vld_ff <= 1'b0;
            dat_ff <= '0;
        end else if (ce) begin
            acc_ff <= nxt_acc;
            cnt_ff <= nxt_cnt;
            vld_ff <= nxt_vld;
            dat_ff <= nxt_dat;
        end
    end

    assign out_valid = vld_ff;
    assign out_data  = dat_ff;

endmodule
`default_nettype wire

//--- hdl/pfoc_top.sv
// Packet format and averaging control with AHB-Lite register slave
`default_nettype none
module pfoc_top #(
    parameter int NUM_CH   = pfoc_pkg::NUM_CH,
    parameter int SAMPLE_W = pfoc_pkg::SAMPLE_W
) (
    // Clock, reset, enable
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    input  wire logic                         ce,
    // AHB-Lite slave
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic                              hreadyout,
    output logic                              hresp,
    output logic [31:0]                       hrdata,
    // Conversion results, all channels at once
    input  wire logic                         conv_valid,
    input  wire logic [NUM_CH*SAMPLE_W-1:0]   conv_data,
    // Formatted packets, one lane per channel
    output logic                              pkt_valid,
    output logic [1:0]                        pkt_size,
    output logic [NUM_CH*pfoc_pkg::LANE_W-1:0] pkt_data
);
    localparam int LW = pfoc_pkg::LANE_W;
    localparam int AW = pfoc_pkg::AVG_W;

    ////////////////////////////////////////////////////////////////////////
    // Lane layouts serve 20-bit samples and at most four lanes
    if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_ch
        $error("pfoc_top: NUM_CH must be 1 to 4");
    end
    if (SAMPLE_W != pfoc_pkg::SAMPLE_W) begin : g_bad_w
        $error("pfoc_top: SAMPLE_W must be 20");
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic                        ph_ff, nxt_ph;
    logic                        ph_wr_ff, nxt_ph_wr;
    logic                        ph_map_ff, nxt_ph_map;
    logic [7:0]                  ph_idx_ff, nxt_ph_idx;
    logic                        rdy_ff, nxt_rdy;
    logic [31:0]                 rdata_ff, nxt_rdata;
    logic [1:0]                  size_ff, nxt_size;
    logic                        fix_ff, nxt_fix;
    logic                        avg_en_ff, nxt_avg_en;
    logic [pfoc_pkg::CODE_W-1:0] code_ff, nxt_code;
    logic [LW-1:0]               pat_ff [NUM_CH];
    logic [LW-1:0]               nxt_pat [NUM_CH];
    logic                        pv_ff, nxt_pv;
    logic [1:0]                  psz_ff, nxt_psz;
    logic [NUM_CH*LW-1:0]        pd_ff, nxt_pd;
    logic [15:0]                 pcnt_ff, nxt_pcnt;
    logic [NUM_CH-1:0]           avg_vld;
    logic [AW-1:0]               avg_dat [NUM_CH];
    logic                        addr_ok;
    logic [7:0]                  pat_off;
    logic                        pat_hit;
    logic                        emit;

    ////////////////////////////////////////////////////////////////////////
    // Lane formatter; packet sits in the low bits
    function automatic logic [LW-1:0] fmt(
        input logic [1:0]          sz,
        input logic                fix,
        input logic                avg,
        input logic [1:0]          ch,
        input logic [SAMPLE_W-1:0] s,
        input logic [AW-1:0]       a,
        input logic [LW-1:0]       p
    );
        logic [LW-1:0] r;
        r = '0;
        case (sz) // RULE3
            pfoc_pkg::SIZE_20: begin // RULE4
                if (fix) begin
                    r = {12'h000, p[LW-1:12]}; // RULE1
                end else if (avg) begin
                    r = {12'h000, a[AW-1:pfoc_pkg::FRAC_W]}; // RULE6
                end else begin
                    r = {12'h000, s};
                end
            end
            pfoc_pkg::SIZE_24: begin // RULE4
                if (fix) begin
                    r = {8'h00, p[LW-1:8]}; // RULE1
                end else if (avg) begin
                    r = {8'h00, a}; // RULE6
                end else begin
                    r = {8'h00, s, 2'h0, ch};
                end
            end
            default: begin // RULE5
                if (fix) begin
                    r = p; // RULE1
                end else if (avg) begin
                    r = {a, 6'h00, ch}; // RULE6
                end else begin
                    r = {s, 10'h000, ch};
                end
            end
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Address decode: word aligned, inside the low 1 KB window
    always_comb begin
        addr_ok = (haddr[31:pfoc_pkg::IDX_MSB+1] == '0)
               && (haddr[pfoc_pkg::IDX_LSB-1:0] == 2'h0)
               && (hsize == 3'h2);
        pat_off = ph_idx_ff - pfoc_pkg::IDX_PATTERN_BASE;
        pat_hit = ph_map_ff && (ph_idx_ff >= pfoc_pkg::IDX_PATTERN_BASE)
               && (pat_off < 8'(NUM_CH));
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus and register next state; one wait state per transfer so the
    // read data and ready can both come from flip-flops
    always_comb begin
        nxt_ph     = ph_ff;
        nxt_ph_wr  = ph_wr_ff;
        nxt_ph_map = ph_map_ff;
        nxt_ph_idx = ph_idx_ff;
        nxt_rdy    = rdy_ff;
        nxt_rdata  = rdata_ff;
        nxt_size   = size_ff;
        nxt_fix    = fix_ff;
        nxt_avg_en = avg_en_ff;
        nxt_code   = code_ff;
        for (int i = 0; i < NUM_CH; i++) begin
            nxt_pat[i] = pat_ff[i];
        end
        if (ph_ff) begin
            // Data phase: hwdata is on the bus now
            nxt_ph    = 1'b0;
            nxt_rdy   = 1'b1;
            nxt_rdata = 32'h00000000;
            if (ph_wr_ff) begin
                if (ph_map_ff
                    && ph_idx_ff == pfoc_pkg::IDX_PACKET_FORMAT) begin
                    nxt_size = hwdata[pfoc_pkg::SIZE_MSB:pfoc_pkg::SIZE_LSB];
                    nxt_fix  = hwdata[pfoc_pkg::FIXED_PAT_BIT];
                end
                if (ph_map_ff && ph_idx_ff == pfoc_pkg::IDX_AVG_CONTROL) begin
                    nxt_avg_en = hwdata[pfoc_pkg::AVG_EN_BIT]; // RULE7
                    // Code change while enabled is the host's lookout
                    nxt_code = hwdata[pfoc_pkg::AVG_CODE_MSB:
                                      pfoc_pkg::AVG_CODE_LSB]; // RULE8
                end
                if (pat_hit) begin
                    nxt_pat[pat_off[1:0]] = hwdata;
                end
            end else begin
                // Reserved bits and unmapped words read as zero
                if (ph_map_ff
                    && ph_idx_ff == pfoc_pkg::IDX_PACKET_FORMAT) begin
                    nxt_rdata[pfoc_pkg::SIZE_MSB:pfoc_pkg::SIZE_LSB] =
                        size_ff;
                    nxt_rdata[pfoc_pkg::FIXED_PAT_BIT] = fix_ff;
                end
                if (ph_map_ff && ph_idx_ff == pfoc_pkg::IDX_AVG_CONTROL) begin
                    nxt_rdata[pfoc_pkg::AVG_EN_BIT] = avg_en_ff;
                    nxt_rdata[pfoc_pkg::AVG_CODE_MSB:
                              pfoc_pkg::AVG_CODE_LSB] = code_ff;
                end
                if (pat_hit) begin
                    nxt_rdata = pat_ff[pat_off[1:0]];
                end
                if (ph_map_ff && ph_idx_ff == pfoc_pkg::IDX_STATUS) begin
                    nxt_rdata[pfoc_pkg::STAT_AVG_BIT] = avg_en_ff;
                    nxt_rdata[pfoc_pkg::STAT_FIX_BIT] = fix_ff;
                    nxt_rdata[31:pfoc_pkg::STAT_CNT_LSB] = pcnt_ff;
                end
            end
        end else if (hsel && hready && htrans[1]) begin
            // Address phase of a NONSEQ or SEQ transfer
            nxt_ph     = 1'b1;
            nxt_ph_wr  = hwrite;
            nxt_ph_map = addr_ok;
            nxt_ph_idx = haddr[pfoc_pkg::IDX_MSB:pfoc_pkg::IDX_LSB];
            nxt_rdy    = 1'b0;
        end
    end

    // Bus and register state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_ff     <= 1'b0;
            ph_wr_ff  <= 1'b0;
            ph_map_ff <= 1'b0;
            ph_idx_ff <= 8'h00;
            rdy_ff    <= 1'b1;
            rdata_ff  <= 32'h00000000;
            size_ff   <= pfoc_pkg::PACKET_FORMAT_RST[pfoc_pkg::SIZE_MSB:
                                                     pfoc_pkg::SIZE_LSB];
            fix_ff    <= pfoc_pkg::PACKET_FORMAT_RST[pfoc_pkg::FIXED_PAT_BIT];
            avg_en_ff <= pfoc_pkg::AVG_CONTROL_RST[pfoc_pkg::AVG_EN_BIT];
            code_ff   <= pfoc_pkg::AVG_CONTROL_RST[pfoc_pkg::AVG_CODE_MSB:
                                                   pfoc_pkg::AVG_CODE_LSB];
            for (int i = 0; i < NUM_CH; i++) begin
                pat_ff[i] <= pfoc_pkg::PATTERN_RST;
            end
        end else if (ce) begin
            ph_ff     <= nxt_ph;
            ph_wr_ff  <= nxt_ph_wr;
            ph_map_ff <= nxt_ph_map;
            ph_idx_ff <= nxt_ph_idx;
            rdy_ff    <= nxt_rdy;
            rdata_ff  <= nxt_rdata;
            size_ff   <= nxt_size;
            fix_ff    <= nxt_fix;
            avg_en_ff <= nxt_avg_en;
            code_ff   <= nxt_code;
            for (int i = 0; i < NUM_CH; i++) begin
                pat_ff[i] <= nxt_pat[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One averaging engine per channel
    for (genvar c = 0; c < NUM_CH; c++) begin : g_avg
        pfoc_avg #(
            .SAMPLE_W (SAMPLE_W)
        ) u_avg (
            .hclk      (hclk),
            .hresetn   (hresetn),
            .ce        (ce),
            .avg_en    (avg_en_ff),
            .avg_code  (code_ff),
            .in_valid  (conv_valid),
            .in_data   (conv_data[c*SAMPLE_W +: SAMPLE_W]),
            .out_valid (avg_vld[c]),
            .out_data  (avg_dat[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // One packet per conversion or per finished group; the fixed
    // pattern keeps the cadence of real data
    always_comb begin
        emit = avg_en_ff ? avg_vld[0] : conv_valid; // RULE7 RULE10
        nxt_pv   = emit;
        nxt_psz  = psz_ff;
        nxt_pd   = pd_ff;
        nxt_pcnt = pcnt_ff;
        if (emit) begin
            nxt_psz  = size_ff; // RULE3
            nxt_pcnt = pcnt_ff + 16'h0001;
            for (int i = 0; i < NUM_CH; i++) begin
                nxt_pd[i*LW +: LW] = fmt(size_ff, fix_ff, avg_en_ff,
                                         2'(i),
                                         conv_data[i*SAMPLE_W +: SAMPLE_W],
                                         avg_dat[i], pat_ff[i]); // RULE6
            end
        end
    end

    // Packet output registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pv_ff   <= 1'b0;
            psz_ff  <= pfoc_pkg::PACKET_FORMAT_RST[pfoc_pkg::SIZE_MSB:
                                                   pfoc_pkg::SIZE_LSB];
            pd_ff   <= '0;
            pcnt_ff <= 16'h0000;
        end else if (ce) begin
            pv_ff   <= nxt_pv;
            psz_ff  <= nxt_psz;
            pd_ff   <= nxt_pd;
            pcnt_ff <= nxt_pcnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; response is always OKAY
    assign hreadyout = rdy_ff;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_ff;
    assign pkt_valid = pv_ff;
    assign pkt_size  = psz_ff;
    assign pkt_data  = pd_ff;

endmodule
`default_nettype wire

//--- tb/pfoc_host_model.sv
// Host model receiving the formatted packets
`default_nettype none
module pfoc_host_model #(
    parameter int NUM_CH = pfoc_pkg::NUM_CH
) (
    // Clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // Packets in
    input  wire logic                 pkt_valid,
    input  wire logic [1:0]           pkt_size,
    input  wire logic [NUM_CH*32-1:0] pkt_data,
    // Last packet and running count
    output logic [NUM_CH*32-1:0]      rx_data,
    output logic [1:0]                rx_size,
    output logic [15:0]               rx_count
);
    timeunit 1ns;
    timeprecision 1ps;

    // Packet stands one cycle, so latch it; pattern packets prove link
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_data  <= '0;
            rx_size  <= 2'h0;
            rx_count <= 16'h0;
        end else if (pkt_valid) begin
            rx_data  <= pkt_data;
            rx_size  <= pkt_size;
            rx_count <= rx_count + 16'h1;
        end
    end
endmodule
`default_nettype wire

//--- tb/pfoc_top_sva.sv
// Checker for bus handshake and packet stream
`default_nettype none
module pfoc_top_sva #(
    parameter int NUM_CH = pfoc_pkg::NUM_CH
) (
    // Clock, reset, enable
    input wire logic                 hclk,
    input wire logic                 hresetn,
    input wire logic                 ce,
    // Register bus
    input wire logic                 hsel,
    input wire logic [31:0]          haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic [2:0]           hsize,
    input wire logic [31:0]          hwdata,
    input wire logic                 hready,
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    // Conversions and packets
    input wire logic                 conv_valid,
    input wire logic                 pkt_valid,
    input wire logic [1:0]           pkt_size,
    input wire logic [NUM_CH*32-1:0] pkt_data
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] A_AVG = 32'(pfoc_pkg::IDX_AVG_CONTROL) << 2;
    logic take, pw_ff, nxt_pw, en_ff, nxt_en;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////////////
    // Shadow of averaging enable; its write cycle may still see old mode
    assign take = ce && hsel && hready && htrans[1] && hreadyout;
    always_comb begin
        nxt_pw = ce ? take && hwrite && hsize == 3'h2 && haddr == A_AVG
                    : pw_ff;
        nxt_en = ce && pw_ff ? hwdata[pfoc_pkg::AVG_EN_BIT] : en_ff;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pw_ff <= 1'b0;
            en_ff <= 1'b0;
        end else begin
            pw_ff <= nxt_pw;
            en_ff <= nxt_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus: exactly one wait state, always OKAY
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not OKAY");
    a_wait_one: assert property (take |=> !hreadyout)
        else $error("no wait state");
    a_ready_back: assert property (!hreadyout && ce |=> hreadyout)
        else $error("wait state too long");

    // Packets: cause, timing, holding, lane 0 upper bits
    a_plain_next: assert property (
        ce && conv_valid && !en_ff && !pw_ff |=> pkt_valid)
        else $error("no packet after conversion");
    a_pkt_cause: assert property (
        pkt_valid && $past(ce) |-> $past(conv_valid) || $past(conv_valid, 2))
        else $error("packet without conversion");
    a_pkt_hold: assert property (
        !pkt_valid |-> $stable(pkt_data) && $stable(pkt_size))
        else $error("packet moved while idle");
    a_size20_top: assert property (
        pkt_valid && pkt_size == pfoc_pkg::SIZE_20
        |-> pkt_data[31:20] == 12'h0)
        else $error("20-bit packet upper bits set");
    a_size24_top: assert property (
        pkt_valid && pkt_size == pfoc_pkg::SIZE_24
        |-> pkt_data[31:24] == 8'h0)
        else $error("24-bit packet upper bits set");
endmodule

bind pfoc_top pfoc_top_sva #(.NUM_CH(NUM_CH)) u_sva (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .conv_valid(conv_valid), .pkt_valid(pkt_valid),
    .pkt_size(pkt_size), .pkt_data(pkt_data)
);
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the packet format block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] A_FMT = 32'(pfoc_pkg::IDX_PACKET_FORMAT) << 2;
    localparam logic [31:0] A_AVG = 32'(pfoc_pkg::IDX_AVG_CONTROL) << 2;
    localparam logic [31:0] A_PAT = 32'(pfoc_pkg::IDX_PATTERN_BASE) << 2;
    localparam logic [19:0] S0    = 20'h80a51;
    localparam logic [31:0] P0    = 32'h8765_4321;
    localparam logic [31:0] PSTEP = 32'h1111_1111;

    logic         hclk, hresetn, ce, hsel, hwrite, hready, hreadyout;
    logic         hresp, conv_valid, pkt_valid;
    logic [1:0]   htrans, pkt_size, rx_size;
    logic [2:0]   hsize;
    logic [31:0]  haddr, hwdata, hrdata;
    logic [79:0]  conv_data;
    logic [127:0] pkt_data, rx_data;
    logic [15:0]  rx_count, npk;
    int           n_errors, comparisons;

    // Sole slave drives the bus ready
    assign hready = hreadyout;
    pfoc_top u_dut (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .conv_valid(conv_valid),
        .conv_data(conv_data), .pkt_valid(pkt_valid),
        .pkt_size(pkt_size), .pkt_data(pkt_data)
    );
    pfoc_host_model u_host (
        .hclk(hclk), .hresetn(hresetn), .pkt_valid(pkt_valid),
        .pkt_size(pkt_size), .pkt_data(pkt_data), .rx_data(rx_data),
        .rx_size(rx_size), .rx_count(rx_count)
    );

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Verdict and comparison
    task automatic print_verdict();
        if (n_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Bounded wait; a stuck slave ends the run
    task automatic wait_ready();
        for (int t = 0; t < 50; t++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1)
                return;
        end
        chk(32'(hreadyout), 32'h1, "bus timeout");
        print_verdict();
    endtask

    // Single word transfer; d is the read's expected data
    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        if (!w)
            chk(hrdata, d, "read");
    endtask

    // One conversion set; lane c gets s0 + c * 0x1000
    task automatic conv(input logic [19:0] s0);
        @(posedge hclk);
        conv_valid <= 1'b1;
        for (int c = 0; c < 4; c++)
            conv_data[c*20 +: 20] <= s0 + (20'(c) << 12);
        @(posedge hclk);
        conv_valid <= 1'b0;
        conv_data  <= ~conv_data;
    endtask

    // Wait for packet n, then check size and every lane
    task automatic chk_pkt(input logic [15:0] n, input logic [1:0] sz,
                           input logic fx, av, input logic [19:0] s0,
                           input logic [23:0] a0, da);
        logic [31:0] p, w32;
        logic [23:0] a, w24;
        logic [19:0] s, w20;
        for (int t = 0; t < 20 && rx_count !== n; t++)
            @(posedge hclk);
        chk({16'h0, rx_count}, {16'h0, n}, "count");
        if (rx_count !== n)
            print_verdict();
        chk({30'h0, rx_size}, {30'h0, sz}, "size");
        for (int c = 0; c < 4; c++) begin
            s = s0 + (20'(c) << 12);
            a = a0 + 24'(c) * da;
            p = P0 + 32'(c) * PSTEP;
            {w32, w24, w20} = {s, 10'h0, 2'(c), s, 2'h0, 2'(c), s};
            if (fx)
                {w32, w24, w20} = {p, p[31:8], p[31:12]};
            else if (av)
                {w32, w24, w20} = {a, 6'h0, 2'(c), a, a[23:4]};
            chk(rx_data[c*32 +: 32], sz[1] ? w32 : sz[0] ? {8'h0, w24}
                : {12'h0, w20}, "lane");
        end
    endtask

    // Averaging run; enable off before the code changes
    task automatic avg_run(input logic [3:0] code, input logic [1:0] sz);
        int n;
        int sum;
        n   = 2 << code;
        sum = 0;
        npk = rx_count + 16'h1;
        bus(1'b1, A_FMT, {30'h0, sz});
        bus(1'b1, A_AVG, {28'h0, code});
        bus(1'b1, A_AVG, {24'h0, 4'h8, code});
        for (int k = 1; k <= n; k++) begin
            conv(20'(16 * k));
            sum += 16 * k;
            if (k == n - 1) begin
                repeat (4) @(posedge hclk);
                chk({16'h0, rx_count}, {16'h0, npk - 16'h1}, "early");
            end
        end
        chk_pkt(npk, sz, 1'b0, 1'b1, 20'h0, 24'((sum * 16) >>> (code + 1)),
                24'((n * 32'h0001_0000) >>> (code + 1)));
        bus(1'b1, A_AVG, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        hresetn    = 1'b0;
        ce         = 1'b1;
        hsel       = 1'b0;
        htrans     = 2'h0;
        hsize      = 3'h2;
        conv_valid = 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values, reserved bits, unmapped and misaligned
        bus(1'b0, A_FMT, 32'h1);
        bus(1'b0, A_AVG, 32'h0);
        bus(1'b1, A_FMT, 32'hffff_ffff);
        bus(1'b0, A_FMT, 32'h7);
        bus(1'b1, A_AVG, 32'hffff_ffff);
        bus(1'b0, A_AVG, 32'h8f);
        bus(1'b1, A_AVG, 32'h0);
        bus(1'b1, 32'h3fc, 32'hffff_ffff);
        bus(1'b0, 32'h3fc, 32'h0);
        bus(1'b0, A_FMT + 32'h1, 32'h0);
        // Pattern values written and read back
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, A_PAT + 32'(4 * c), P0 + 32'(c) * PSTEP);
            bus(1'b0, A_PAT + 32'(4 * c), P0 + 32'(c) * PSTEP);
        end
        // Every size code, plain and fixed pattern
        for (int m = 0; m < 8; m++) begin
            bus(1'b1, A_FMT, 32'(m));
            npk = rx_count + 16'h1;
            conv(S0);
            chk_pkt(npk, 2'(m), m[2], 1'b0, S0, 24'h0, 24'h0);
        end
        bus(1'b0, A_PAT + 32'h10, 32'h0008_0002);
        avg_run(4'h0, 2'h0);
        avg_run(4'h1, 2'h1);
        avg_run(4'h2, 2'h3);
        print_verdict();
    end
endmodule
`default_nettype wire
